// *** src/iobr_ctrl.sv ***
// clock dividers, i/o strobes, dram refresh and standby control
// Operation
// - io clock is bus clock divided by one up to eight
// - bus clock is input clock direct, halved or doubled
// - a control input silences the clock output pin
// - zero to seven waits in i/o reads, writes and late intack
// - separate zero to seven waits in early intack portion
// - four i/o strobes: fetch, request, read and write
// - heartbeat cycle mimics a legacy instruction fetch
// - refresh requests issued periodically at programmed interval
// - bursts start only while enabled, programmed burst per request
// - refresh transaction asserts column before row strobe
// - byte enables and chip selects active during refresh
// - separate wait counts in refresh states one, two, three
// - missed count up per request, down per finished burst
// - no new burst while bus lent; missed ones done afterwards
// - standby sleep stops all clocks but enabled timer zero
// - standby entry drives standby and halt indicators low
// - in standby bus controls inactive, address lines high
// - exit on reset, nmi, enabled irq, or optional bus request
// - plain sleep gates internal clocks; only standby pin low
// - warm-up counter runs before clocking resumes
`timescale 1ns/1ps
module iobr_ctrl #(
    parameter int REF_W = 8,
    parameter int BURST_W = 4,
    parameter int MISS_W = 8,
    parameter int WARM_CYCLES = iobr_pkg::WARM_BASE_CYCLES
) (
    input  wire logic                          I_MCLK,
    input  wire logic                          I_RSTN,
    input  wire logic [1:0]                    I_CLK_SRC,
    input  wire logic                          I_CLKOUT_DIS,
    input  wire logic [iobr_pkg::RATIO_W-1:0]  I_IO_DIV,
    input  wire logic [iobr_pkg::WAIT_W-1:0]   I_IO_WAITS,
    input  wire logic [iobr_pkg::WAIT_W-1:0]   I_ACK_WAITS,
    input  wire logic                          I_IO_RD_REQ,
    input  wire logic                          I_IO_WR_REQ,
    input  wire logic                          I_INTACK_REQ,
    input  wire logic                          I_BEAT_REQ,
    input  wire logic [REF_W-1:0]              I_REF_INTERVAL,
    input  wire logic                          I_REF_EN,
    input  wire logic [BURST_W-1:0]            I_REF_BURST,
    input  wire logic [iobr_pkg::WAIT_W-1:0]   I_REF_T1_WAITS,
    input  wire logic [iobr_pkg::WAIT_W-1:0]   I_REF_T2_WAITS,
    input  wire logic [iobr_pkg::WAIT_W-1:0]   I_REF_T3_WAITS,
    input  wire logic                          I_SLEEP,
    input  wire logic                          I_STBY_EN,
    input  wire logic                          I_BUS_REQUEST_INPUT_EXIT_EN,
    input  wire logic [iobr_pkg::WARM_SEL_W-1:0] I_WARM_SEL,
    input  wire logic                          I_TMR0_EN,
    input  wire logic [3:0]                    I_IRQ_EN,
    input  wire logic                          I_BUS_REQ_N,
    input  wire logic                          I_NMI_N,
    input  wire logic [3:0]                    I_IRQ_N,
    output logic                               O_BUS_CLOCK,
    output logic                               O_CLOCK_OUT,
    output logic                               O_IO_CLOCK,
    output logic                               O_TMR0_TICK,
    output logic                               O_FETCH_N,
    output logic                               O_IO_REQUEST_STROBE_N,
    output logic                               O_IO_READ_STROBE_N,
    output logic                               O_IO_WRITE_STROBE_N,
    output logic                               O_IO_BUSY,
    output logic                               O_IO_DONE,
    output logic                               O_REF_ROW_N,
    output logic                               O_REF_AUX_N,
    output logic                               O_REF_COL_N,
    output logic                               O_UBE_N,
    output logic                               O_LBE_N,
    output logic                               O_REF_CS_N,
    output logic [MISS_W-1:0]                  O_MISSED,
    output logic                               O_STBY_N,
    output logic                               O_HALT_N,
    output logic                               O_ADDR_HIGH
);
    import iobr_pkg::*;

    // pins cross in through two flops; stage one feeds only stage two
    logic [SYNC_W-1:0] sync_a;
    logic [SYNC_W-1:0] sync_b;
    always_ff @(posedge I_MCLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            sync_a <= '1;
            sync_b <= '1;
        end else begin
            sync_a <= {I_BUS_REQ_N, I_NMI_N, I_IRQ_N};
            sync_b <= sync_a;
        end
    end
    logic bus_request_input;
    logic nmi_evt;
    logic irq_evt;
    assign bus_request_input = !sync_b[5];
    assign nmi_evt = !sync_b[4];
    assign irq_evt = |(~sync_b[3:0] & I_IRQ_EN);

    // power state and warm-up
    iobr_pw_type pw, next_pw;
    logic [31:0] warm, next_warm;
    logic exit_evt;
    assign exit_evt = nmi_evt || irq_evt || (bus_request_input && I_BUS_REQUEST_INPUT_EXIT_EN);
    always_comb begin
        next_pw = pw;
        next_warm = warm;
        unique case (pw)
            PW_RUN: begin
                if (I_SLEEP) begin
                    next_pw = I_STBY_EN ? PW_STANDBY : PW_SLEEP;
                end
            end
            PW_SLEEP: begin
                if (exit_evt) begin
                    next_pw = PW_RUN;
                end
            end
            PW_STANDBY: begin
                if (exit_evt) begin
                    next_pw = PW_WARM;
                    next_warm = 32'(WARM_CYCLES) << I_WARM_SEL;
                end
            end
            PW_WARM: begin
                next_warm = warm - 32'h1;
                if (warm <= 32'h1) begin
                    next_pw = PW_RUN;
                end
            end
        endcase
    end
    always_ff @(posedge I_MCLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            pw <= PW_RUN;
            warm <= '0;
        end else begin
            pw <= next_pw;
            warm <= next_warm;
        end
    end
    logic osc_on;
    logic run;
    assign osc_on = (pw == PW_RUN) || (pw == PW_SLEEP);
    assign run = (pw == PW_RUN);

    // bus clock tick from the input clock; ticks vanish in standby
    logic [1:0] bdiv, next_bdiv;
    logic bus_tick;
    logic div_run;
    logic [1:0] bdiv_top;
    assign bdiv_top = (I_CLK_SRC == SRC_HALF) ? BUS_DIV_HALF :
                      (I_CLK_SRC == SRC_DOUBLE) ? 2'h0 : BUS_DIV_DIRECT;
    assign bus_tick = osc_on && (bdiv >= bdiv_top);
    // divider keeps counting in standby only to feed timer zero
    assign div_run = osc_on || (I_TMR0_EN && pw == PW_STANDBY);
    logic [RATIO_W-1:0] idiv, next_idiv;
    logic io_tick;
    assign io_tick = bus_tick && (idiv >= I_IO_DIV);
    logic bclk, next_bclk;
    logic iclk, next_iclk;
    always_comb begin
        next_bdiv = (div_run && bdiv >= bdiv_top) ? 2'h0
                    : (div_run ? bdiv + 2'h1 : bdiv);
        next_idiv = idiv;
        if (bus_tick) begin
            next_idiv = io_tick ? '0 : idiv + 3'h1;
        end
        next_bclk = bus_tick ? !bclk : bclk;
        next_iclk = io_tick ? !iclk : iclk;
    end
    always_ff @(posedge I_MCLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            bdiv <= '0;
            idiv <= '0;
            bclk <= 1'b0;
            iclk <= 1'b0;
        end else begin
            bdiv <= next_bdiv;
            idiv <= next_idiv;
            bclk <= next_bclk;
            iclk <= next_iclk;
        end
    end
    assign O_BUS_CLOCK = bclk;
    assign O_IO_CLOCK = iclk;
    assign O_CLOCK_OUT = bclk && !I_CLKOUT_DIS;
    // timer zero keeps its tick in every sleep state when enabled
    assign O_TMR0_TICK = I_TMR0_EN && div_run
                         && (bdiv >= bdiv_top);

    // i/o bus cycle engine, stepped on io clock ticks
    iobr_io_type io, next_io;
    iobr_cyc_type cyc, next_cyc;
    logic [WAIT_W-1:0] iow, next_iow;
    logic io_done, next_io_done;
    logic io_step;
    assign io_step = run && io_tick;
    always_comb begin
        next_io = io;
        next_cyc = cyc;
        next_iow = iow;
        next_io_done = 1'b0;
        if (io_step) begin
            unique case (io)
                IO_IDLE: begin
                    next_iow = '0;
                    if (I_INTACK_REQ) begin
                        next_cyc = CYC_INTACK;
                        next_io = IO_T1;
                    end else if (I_IO_RD_REQ) begin
                        next_cyc = CYC_READ;
                        next_io = IO_T1;
                    end else if (I_IO_WR_REQ) begin
                        next_cyc = CYC_WRITE;
                        next_io = IO_T1;
                    end else if (I_BEAT_REQ) begin
                        next_cyc = CYC_BEAT;
                        next_io = IO_T1;
                    end
                end
                IO_T1: begin
                    if (cyc == CYC_INTACK) begin
                        next_io = IO_EARLY;
                    end else if (cyc == CYC_BEAT) begin
                        next_io = IO_T3;
                    end else begin
                        next_io = IO_WAIT;
                    end
                end
                IO_EARLY: begin
                    if (iow >= I_ACK_WAITS) begin
                        next_iow = '0;
                        next_io = IO_WAIT;
                    end else begin
                        next_iow = iow + 3'h1;
                    end
                end
                IO_WAIT: begin
                    if (iow >= I_IO_WAITS) begin
                        next_io = IO_T3;
                    end else begin
                        next_iow = iow + 3'h1;
                    end
                end
                IO_T3: begin
                    next_io = IO_IDLE;
                    next_io_done = 1'b1;
                end
            endcase
        end
    end
    always_ff @(posedge I_MCLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            io <= IO_IDLE;
            cyc <= CYC_READ;
            iow <= '0;
            io_done <= 1'b0;
        end else begin
            io <= next_io;
            cyc <= next_cyc;
            iow <= next_iow;
            io_done <= next_io_done;
        end
    end
    logic io_act;
    logic data_ph;
    // strobes stay quiet through warm-up as well
    assign io_act = (io != IO_IDLE) && O_HALT_N;
    assign data_ph = io_act && (io != IO_T1) && (io != IO_EARLY);
    // fetch mimic: fetch strobe spans the cycle, request in late part
    assign O_FETCH_N = !(io_act && (cyc == CYC_INTACK
                         || cyc == CYC_BEAT));
    assign O_IO_REQUEST_STROBE_N = !(io_act && (cyc != CYC_BEAT || io == IO_T3));
    assign O_IO_READ_STROBE_N = !(data_ph && (cyc == CYC_READ
                        || cyc == CYC_INTACK));
    assign O_IO_WRITE_STROBE_N = !(data_ph && cyc == CYC_WRITE);
    assign O_IO_BUSY = io != IO_IDLE;
    assign O_IO_DONE = io_done;

    // refresh interval, missed count and burst engine
    logic [REF_W-1:0] ivl, next_ivl;
    logic ref_req;
    assign ref_req = run && bus_tick && I_REF_EN && (ivl == '0);
    iobr_rf_type rf, next_rf;
    logic [WAIT_W-1:0] rfw, next_rfw;
    logic [BURST_W-1:0] nb, next_nb;
    logic [MISS_W-1:0] miss, next_miss;
    logic burst_end;
    logic rf_step;
    logic rfw_ok;
    assign rf_step = run && bus_tick;
    always_comb begin
        unique case (rf)
            RF_T1: rfw_ok = rfw >= I_REF_T1_WAITS;
            RF_T2: rfw_ok = rfw >= I_REF_T2_WAITS;
            RF_T3: rfw_ok = rfw >= I_REF_T3_WAITS;
            default: rfw_ok = 1'b1;
        endcase
    end
    always_comb begin
        next_ivl = ivl;
        next_rf = rf;
        next_rfw = rfw;
        next_nb = nb;
        burst_end = 1'b0;
        if (!I_REF_EN) begin
            next_ivl = I_REF_INTERVAL;
        end else if (rf_step) begin
            next_ivl = (ivl == '0) ? I_REF_INTERVAL : ivl - 1'b1;
        end
        if (rf_step) begin
            unique case (rf)
                RF_IDLE: begin
                    next_rfw = '0;
                    next_nb = '0;
                    // held off while the bus is lent out
                    if (I_REF_EN && !bus_request_input && miss != '0) begin
                        next_rf = RF_T1;
                    end
                end
                RF_T1, RF_T2: begin
                    next_rfw = rfw + 3'h1;
                    if (rfw_ok) begin
                        next_rfw = '0;
                        next_rf = (rf == RF_T1) ? RF_T2 : RF_T3;
                    end
                end
                RF_T3: begin
                    next_rfw = rfw + 3'h1;
                    if (rfw_ok) begin
                        next_rfw = '0;
                        // burst stays whole even if the bus is requested
                        if (nb + 1'b1 >= I_REF_BURST) begin
                            next_rf = RF_IDLE;
                            burst_end = 1'b1;
                        end else begin
                            next_nb = nb + 1'b1;
                            next_rf = RF_T1;
                        end
                    end
                end
            endcase
        end
        // request and completion together leave the count unchanged
        next_miss = miss;
        if (ref_req && !burst_end && miss != '1) begin
            next_miss = miss + 1'b1;
        end else if (burst_end && !ref_req) begin
            next_miss = miss - 1'b1;
        end
    end
    always_ff @(posedge I_MCLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            ivl <= '0;
            rf <= RF_IDLE;
            rfw <= '0;
            nb <= '0;
            miss <= '0;
        end else begin
            ivl <= next_ivl;
            rf <= next_rf;
            rfw <= next_rfw;
            nb <= next_nb;
            miss <= next_miss;
        end
    end
    logic rf_act;
    assign rf_act = (rf != RF_IDLE) && O_HALT_N;
    assign O_REF_COL_N = !(rf_act && rf != RF_T3);
    assign O_REF_AUX_N = !(rf_act && rf != RF_T3);
    assign O_REF_ROW_N = !(rf_act && rf == RF_T2);
    assign O_UBE_N = !rf_act;
    assign O_LBE_N = !rf_act;
    assign O_REF_CS_N = !rf_act;
    assign O_MISSED = miss;

    assign O_STBY_N = run;
    assign O_HALT_N = !(pw == PW_STANDBY || pw == PW_WARM);
    assign O_ADDR_HIGH = (pw == PW_STANDBY);
endmodule : iobr_ctrl

// *** src/iobr_pkg.sv ***
// constants and types shared by the bus, refresh and standby control
package iobr_pkg;
    localparam int WAIT_W = 3;
    localparam int RATIO_W = 3;
    localparam logic [WAIT_W-1:0] WAIT_MAX = 3'h7;
    localparam logic [RATIO_W-1:0] IO_DIV_MAX = 3'h7;
    localparam logic [1:0] SRC_DIRECT = 2'h0;
    localparam logic [1:0] SRC_HALF = 2'h1;
    localparam logic [1:0] SRC_DOUBLE = 2'h2;
    localparam logic [1:0] BUS_DIV_DIRECT = 2'h1;
    localparam logic [1:0] BUS_DIV_HALF = 2'h3;
    localparam int SYNC_W = 6;
    localparam int WARM_SEL_W = 2;
    localparam int WARM_BASE_CYCLES = 8192;
    typedef enum logic [2:0] {
        IO_IDLE, IO_T1, IO_EARLY, IO_WAIT, IO_T3
    } iobr_io_type;
    typedef enum logic [1:0] {
        CYC_READ, CYC_WRITE, CYC_INTACK, CYC_BEAT
    } iobr_cyc_type;
    typedef enum logic [1:0] {
        RF_IDLE, RF_T1, RF_T2, RF_T3
    } iobr_rf_type;
    typedef enum logic [1:0] {
        PW_RUN, PW_SLEEP, PW_STANDBY, PW_WARM
    } iobr_pw_type;
endpackage : iobr_pkg

// *** tb/iobr_ctrl_props.sv ***
// port assertions for the bus, refresh and standby control
`timescale 1ns/1ps
module iobr_ctrl_props
    import iobr_pkg::*;
#(
    parameter int MISS_W = 8
) (
    input wire logic              I_MCLK,
    input wire logic              I_RSTN,
    input wire logic [1:0]        I_CLK_SRC,
    input wire logic              I_CLKOUT_DIS,
    input wire logic              O_BUS_CLOCK,
    input wire logic              O_CLOCK_OUT,
    input wire logic              O_IO_CLOCK,
    input wire logic              O_IO_REQUEST_STROBE_N,
    input wire logic              O_IO_READ_STROBE_N,
    input wire logic              O_IO_WRITE_STROBE_N,
    input wire logic              O_REF_ROW_N,
    input wire logic              O_REF_COL_N,
    input wire logic              O_UBE_N,
    input wire logic              O_LBE_N,
    input wire logic              O_REF_CS_N,
    input wire logic [MISS_W-1:0] O_MISSED,
    input wire logic              O_STBY_N,
    input wire logic              O_HALT_N,
    input wire logic              O_ADDR_HIGH
);
    default clocking cb @(posedge I_MCLK); endclocking
    default disable iff (!I_RSTN);
    property p_clkout;
        I_CLKOUT_DIS |-> !O_CLOCK_OUT;
    endproperty
    a_clkout: assert property (p_clkout) else $error("clock out on");
    // three cycles settle the divider after a source change
    property p_double;
        (I_CLK_SRC == SRC_DOUBLE && O_STBY_N) [*3] |-> $changed(O_BUS_CLOCK);
    endproperty
    a_double: assert property (p_double) else $error("bus clock slow");
    property p_col_first;
        $fell(O_REF_ROW_N) |-> $past(!O_REF_COL_N);
    endproperty
    a_col_first: assert property (p_col_first) else $error("row first");
    property p_ref_sel;
        !O_REF_COL_N |-> !(O_UBE_N | O_LBE_N | O_REF_CS_N);
    endproperty
    a_ref_sel: assert property (p_ref_sel) else $error("selects off");
    property p_miss_step;
        !$stable(O_MISSED) |-> O_MISSED - $past(O_MISSED) == 1
            || $past(O_MISSED) - O_MISSED == 1;
    endproperty
    a_miss_step: assert property (p_miss_step) else $error("count jump");
    property p_stby_pins;
        O_ADDR_HIGH |-> !O_STBY_N && !O_HALT_N;
    endproperty
    a_stby_pins: assert property (p_stby_pins) else $error("indicators");
    property p_stby_bus;
        O_ADDR_HIGH |-> &{O_IO_REQUEST_STROBE_N, O_IO_READ_STROBE_N, O_IO_WRITE_STROBE_N, O_REF_ROW_N, O_REF_CS_N};
    endproperty
    a_stby_bus: assert property (p_stby_bus) else $error("bus active");
    property p_frozen;
        O_ADDR_HIGH [*2] |-> $stable(O_BUS_CLOCK) && $stable(O_IO_CLOCK);
    endproperty
    a_frozen: assert property (p_frozen) else $error("clock runs");
endmodule : iobr_ctrl_props
bind iobr_ctrl iobr_ctrl_props #(.MISS_W(MISS_W)) iobr_ctrl_props_inst (
    .I_MCLK, .I_RSTN, .I_CLK_SRC, .I_CLKOUT_DIS, .O_BUS_CLOCK, .O_CLOCK_OUT,
    .O_IO_CLOCK, .O_IO_REQUEST_STROBE_N, .O_IO_READ_STROBE_N, .O_IO_WRITE_STROBE_N, .O_REF_ROW_N, .O_REF_COL_N,
    .O_UBE_N, .O_LBE_N, .O_REF_CS_N, .O_MISSED, .O_STBY_N, .O_HALT_N,
    .O_ADDR_HIGH
);

// *** tb/iobr_far_model.sv ***
// far side: dram refresh counter and external pin drivers
`timescale 1ns/1ps
module iobr_far_model (
    input  wire logic       clk,
    input  wire logic       row_n,
    input  wire logic       col_n,
    input  wire logic [5:0] pins,
    output logic            bus_request_input_n,
    output logic            nmi_n,
    output logic [3:0]      irq_n,
    output int              n_ref
);
    initial begin
        n_ref = 0;
        {bus_request_input_n, nmi_n, irq_n} = 6'h3F;
    end
    // pins are asynchronous; move them away from the sampling edge
    always @(negedge clk) begin
        {bus_request_input_n, nmi_n, irq_n} <= ~pins;
    end
    // a row fall only refreshes when the column strobe leads it
    always @(negedge row_n) begin
        if (col_n === 1'b0) begin
            n_ref++;
        end
    end
endmodule : iobr_far_model

// *** tb/test_iobr_ctrl.sv ***
// self-checking bench for the bus, refresh and standby control
`timescale 1ns/1ps
module test_iobr_ctrl;
    import iobr_pkg::*;
    localparam int WARM = 4;
    logic        I_MCLK = 1'b0, I_RSTN = 1'b0, I_BUS_REQ_N, I_NMI_N;
    logic [1:0]  I_CLK_SRC, I_WARM_SEL;
    logic [2:0]  I_IO_DIV, I_IO_WAITS, I_ACK_WAITS, seen = 3'h0;
    logic [2:0]  I_REF_T1_WAITS, I_REF_T2_WAITS, I_REF_T3_WAITS;
    logic [3:0]  I_REF_BURST, I_IRQ_EN, I_IRQ_N;
    logic [7:0]  I_REF_INTERVAL, O_MISSED, miss_prev = 8'h0;
    logic        I_CLKOUT_DIS, I_IO_RD_REQ, I_IO_WR_REQ, I_INTACK_REQ;
    logic        I_BEAT_REQ, I_REF_EN, I_SLEEP, I_STBY_EN, I_BUS_REQUEST_INPUT_EXIT_EN;
    logic        I_TMR0_EN, O_BUS_CLOCK, O_CLOCK_OUT, O_IO_CLOCK, O_TMR0_TICK;
    logic        O_FETCH_N, O_IO_REQUEST_STROBE_N, O_IO_READ_STROBE_N, O_IO_WRITE_STROBE_N, O_IO_BUSY, O_IO_DONE;
    logic        O_REF_ROW_N, O_REF_AUX_N, O_REF_COL_N, O_UBE_N, O_LBE_N;
    logic        O_REF_CS_N, O_STBY_N, O_HALT_N, O_ADDR_HIGH, stby_prev = 1'b1;
    logic [5:0]  pins;
    logic [15:0] q_io[$], q_rf[$], q_pw[$];
    int n_errors = 0, compares = 0, cyc = 0, seed = 51184, n_ref, n0, m0;
    int io_len = 0, col_len = 0, row_len = 0, n_tr = 0, gap = 0, warm = 0;
    int gap_on = 0, p, t, aux_len = 0, be_len = 0, tmr = 0;
    iobr_ctrl #(.WARM_CYCLES(WARM)) iobr_ctrl_inst (
        .I_MCLK, .I_RSTN, .I_CLK_SRC, .I_CLKOUT_DIS, .I_IO_DIV, .I_IO_WAITS,
        .I_ACK_WAITS, .I_IO_RD_REQ, .I_IO_WR_REQ, .I_INTACK_REQ, .I_BEAT_REQ,
        .I_REF_INTERVAL, .I_REF_EN, .I_REF_BURST, .I_REF_T1_WAITS,
        .I_REF_T2_WAITS, .I_REF_T3_WAITS, .I_SLEEP, .I_STBY_EN,
        .I_BUS_REQUEST_INPUT_EXIT_EN, .I_WARM_SEL, .I_TMR0_EN, .I_IRQ_EN, .I_BUS_REQ_N,
        .I_NMI_N, .I_IRQ_N, .O_BUS_CLOCK, .O_CLOCK_OUT, .O_IO_CLOCK,
        .O_TMR0_TICK, .O_FETCH_N, .O_IO_REQUEST_STROBE_N, .O_IO_READ_STROBE_N, .O_IO_WRITE_STROBE_N, .O_IO_BUSY,
        .O_IO_DONE, .O_REF_ROW_N, .O_REF_AUX_N, .O_REF_COL_N, .O_UBE_N,
        .O_LBE_N, .O_REF_CS_N, .O_MISSED, .O_STBY_N, .O_HALT_N, .O_ADDR_HIGH
    );
    iobr_far_model iobr_far_model_inst (
        .clk(I_MCLK), .row_n(O_REF_ROW_N), .col_n(O_REF_COL_N), .pins,
        .bus_request_input_n(I_BUS_REQ_N), .nmi_n(I_NMI_N), .irq_n(I_IRQ_N), .n_ref
    );
    always #2.5 I_MCLK = ~I_MCLK;
    task automatic check(input logic [15:0] seen_v, input logic [15:0] exp);
        compares++;
        if (seen_v !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen_v, exp);
        end
    endtask : check
    task automatic test_done;
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : test_done
    task automatic tk(input int n);
        repeat (n) @(negedge I_MCLK);
    endtask : tk
    // bounded wait: 0 busy, 1 standby pin, 2 count empty, 3 notes used
    task automatic wt(input int s, input logic v);
        logic [3:0] f;
        for (int n = 0; n < 3000; n++) begin
            f = {q_rf.size() == 0, O_MISSED == 8'h0, O_STBY_N, O_IO_BUSY};
            if (f[s] === v) break;
            tk(1);
        end
        // a wait that runs out is a failure, not a pass
        if (f[s] !== v) begin
            n_errors++;
        end
    endtask : wt
    always @(posedge I_MCLK) begin
        cyc++;
        if (cyc == 60000) begin
            n_errors++;
            test_done();
        end
    end
    // watcher: lengths in clocks, compared against the oldest note
    always @(posedge I_MCLK) begin
        if (!O_IO_REQUEST_STROBE_N) begin
            io_len++;
            seen |= ~{O_FETCH_N, O_IO_READ_STROBE_N, O_IO_WRITE_STROBE_N};
        end else if (io_len != 0) begin
            if (q_io.size() > 0) check({seen, 13'(io_len)}, q_io.pop_front());
            check(16'(O_IO_DONE), 16'h1);
            io_len = 0;
            seen = 3'h0;
        end
        col_len += !O_REF_COL_N;
        row_len += !O_REF_ROW_N;
        aux_len += !O_REF_AUX_N;
        be_len += !O_UBE_N;
        if (O_REF_COL_N && col_len != 0) begin
            n_tr++;
            if (q_rf.size() > 0) check({8'(row_len), 8'(col_len)}, q_rf.pop_front());
            check(16'(aux_len), 16'(col_len));
            col_len = 0;
            row_len = 0;
            aux_len = 0;
        end
        gap++;
        if (O_MISSED < miss_prev) begin
            if (q_rf.size() > 0) check({8'hF0, 8'(n_tr)}, q_rf.pop_front());
            if (q_rf.size() > 0) check(16'(be_len), q_rf.pop_front());
            n_tr = 0;
            be_len = 0;
        end
        if (O_MISSED > miss_prev) begin
            if (gap_on != 0) check(16'(gap), 16'd128);
            gap = 0;
        end
        miss_prev = O_MISSED;
        warm += !O_STBY_N && !O_HALT_N && !O_ADDR_HIGH;
        tmr += O_TMR0_TICK;
        if (stby_prev && !O_STBY_N && q_pw.size() > 0) check({O_HALT_N, O_ADDR_HIGH}, q_pw.pop_front());
        if (!stby_prev && O_STBY_N) begin
            if (q_pw.size() > 0) check(16'(warm), q_pw.pop_front());
            warm = 0;
        end
        stby_prev = O_STBY_N;
    end
    initial begin
        {I_CLK_SRC, I_WARM_SEL, I_IO_DIV, I_IO_WAITS, I_ACK_WAITS} = '0;
        {I_REF_T1_WAITS, I_REF_T2_WAITS, I_REF_T3_WAITS, I_REF_BURST} = '0;
        {I_IRQ_EN, I_REF_INTERVAL, I_CLKOUT_DIS, I_IO_RD_REQ, I_IO_WR_REQ} = '0;
        {I_INTACK_REQ, I_BEAT_REQ, I_REF_EN, I_SLEEP, I_STBY_EN} = '0;
        {I_BUS_REQUEST_INPUT_EXIT_EN, I_TMR0_EN, pins} = '0;
        tk(20);
        I_RSTN = 1'b1;
        tk(4);
        for (int i = 0; i < 16; i++) begin
            I_CLK_SRC = 2'($unsigned($random(seed)) % 3);
            {I_IO_DIV, I_IO_WAITS, I_ACK_WAITS, I_CLKOUT_DIS} = 10'($random(seed));
            p = (I_CLK_SRC == SRC_HALF) ? 4 : (I_CLK_SRC == SRC_DOUBLE) ? 1 : 2;
            p = p * (I_IO_DIV + 1);
            t = I_IO_WAITS + 3;
            case (i % 4)
                0: q_io.push_back({3'h2, 13'(t * p)});
                1: q_io.push_back({3'h1, 13'(t * p)});
                2: q_io.push_back({3'h6, 13'((t + I_ACK_WAITS + 1) * p)});
                default: q_io.push_back({3'h4, 13'(p)});
            endcase
            tk(40);
            {I_IO_RD_REQ, I_IO_WR_REQ, I_INTACK_REQ, I_BEAT_REQ} = 4'h8 >> (i % 4);
            wt(0, 1'b1);
            // drop the level before the next io tick or it restarts
            wt(0, 1'b0);
            {I_IO_RD_REQ, I_IO_WR_REQ, I_INTACK_REQ, I_BEAT_REQ} = 4'h0;
        end
        I_CLK_SRC = SRC_DIRECT;
        {I_REF_T1_WAITS, I_REF_T2_WAITS, I_REF_T3_WAITS} = 9'($random(seed)) & 9'h0DB;
        I_REF_BURST = 4'(1 + $unsigned($random(seed)) % 3);
        I_REF_INTERVAL = 8'h3F;
        for (int b = 0; b < 3; b++) begin
            repeat (I_REF_BURST) q_rf.push_back({8'(I_REF_T2_WAITS * 2 + 2),
                8'((I_REF_T1_WAITS + I_REF_T2_WAITS) * 2 + 4)});
            q_rf.push_back({8'hF0, 4'h0, I_REF_BURST});
            // selects stay low across the whole burst, all three states
            q_rf.push_back(16'(I_REF_BURST * (I_REF_T1_WAITS
                + I_REF_T2_WAITS + I_REF_T3_WAITS + 3) * 2));
        end
        tk(2);
        I_REF_EN = 1'b1;
        wt(2, 1'b0);
        // let the watcher restart its gap count on this first request
        tk(1);
        gap_on = 1;
        wt(3, 1'b1);
        // lend the bus; misses counted over exactly four intervals
        pins = 6'h20;
        tk(10);
        n0 = n_ref;
        m0 = O_MISSED;
        tk(512);
        check(16'(n_ref), 16'(n0));
        check(16'(O_MISSED), 16'(m0 + 4));
        gap_on = 0;
        pins = 6'h00;
        wt(2, 1'b1);
        check(16'(O_MISSED), 16'h0);
        I_REF_EN = 1'b0;
        tk(150);
        n0 = n_ref;
        tk(300);
        check(16'(n_ref), 16'(n0));
        for (int c = 0; c < 4; c++) begin
            I_STBY_EN = (c != 0);
            I_BUS_REQUEST_INPUT_EXIT_EN = (c == 2);
            I_TMR0_EN = 1'b1;
            I_IRQ_EN = 4'hE;
            I_WARM_SEL = 2'($random(seed));
            q_pw.push_back(I_STBY_EN ? 16'h1 : 16'h2);
            q_pw.push_back(I_STBY_EN ? 16'(WARM << I_WARM_SEL) : 16'h0);
            I_SLEEP = 1'b1;
            tk(1);
            I_SLEEP = 1'b0;
            pins = (c == 2) ? 6'h01 : 6'h21;
            t = tmr;
            tk(20);
            check(16'(O_STBY_N), 16'h0);
            // bus rate ticks still reach timer zero while asleep
            check(16'(tmr - t), 16'hA);
            pins = (c == 1) ? 6'h02 : (c == 2) ? 6'h20 : 6'h10;
            wt(1, 1'b1);
            pins = 6'h00;
            tk(10);
        end
        tk(20);
        test_done();
    end
endmodule : test_iobr_ctrl
